// ===== core/tfc_pkg.sv
// Package with register map, status layout, command codes and carriers for the tape command core.
package tfc_pkg;
	// Register byte offsets on the plain register port.
	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_CNT = 5'h04;
	localparam logic [4:0] OFF_OFS = 5'h08;
	localparam logic [4:0] OFF_TSW = 5'h0C;
	localparam logic [4:0] OFF_ESW = 5'h10;
	localparam int         DW      = 16;

	// Transport status word bit positions.
	localparam int TS_OFFLINE = 0;
	localparam int TS_BOT     = 1;
	localparam int TS_EOT     = 2;
	localparam int TS_REWIND  = 3;
	localparam int TS_WPROT   = 4;
	localparam int TS_EOR     = 5;
	localparam int TS_BUSY    = 6;
	localparam int TS_TMO     = 7;

	// Error status word bit positions.
	localparam int ES_RAW  = 8;
	localparam int ES_RATE = 12;
	localparam int ES_FMT  = 14;
	localparam int ES_TAPE = 15;

	// Command codes taken from the second hex digit of the command word.
	localparam int          CMD_LSB   = 8;
	localparam logic [3:0]  CMD_WRITE = 4'h6;
	localparam logic [3:0]  CMD_ERASE = 4'h7;
	localparam logic [3:0]  CMD_REW   = 4'hA;
	localparam logic [3:0]  CMD_UNLD  = 4'hB;
	localparam logic [3:0]  CMD_UWR   = 4'hC;
	localparam logic [3:0]  CMD_URD   = 4'hD;
	localparam logic [3:0]  CMD_MAINT = 4'hF;

	// Geometry and limits.
	localparam logic [15:0] REC_LIMIT     = 16'h5000;
	localparam int          NUM_TRACKS    = 4;
	localparam int          LP_GAP_IN     = 6;
	localparam int          TACH_PER_IN   = 16;
	localparam logic [15:0] LP_GAP_PULSES = 16'(LP_GAP_IN * TACH_PER_IN);
	localparam logic [15:0] RESET_WORD    = 16'h0000;

	// Ready indicator blink half period.
	localparam int CLK_MHZ        = 250;
	localparam int BLINK_HALF_MS  = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;

	// Sensor and fault inputs from the transport, all asynchronous pins.
	typedef struct packed {
		logic cart;
		logic wprot;
		logic lp;
		logic ew;
		logic end_of_tape;
		logic beginning_of_tape;
		logic tach;
		logic byte_req;
		logic crc_fail;
		logic dropout;
		logic rec_end;
		logic amplitude;
		logic pos_fault;
		logic unexp_int;
		logic timeout;
		logic test_done;
	} tfc_sense_t;

	// Drive outputs towards motor and heads.
	typedef struct packed {
		logic motor_fwd;
		logic motor_rev;
		logic write_en;
		logic erase_en;
		logic crc_chk_en;
		logic preamble_only;
		logic read_en;
	} tfc_drive_t;
endpackage

// ===== core/tfc_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module tfc_sync #(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         clk_i,
	input  wire logic         srst_i,
	// Levels in and out.
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// ===== core/tfc_blink.sv
// Ready indicator driver that is steady, blinking or off.
`timescale 1ns/1ps
module tfc_blink #(
	parameter int HALF_CYC = tfc_pkg::BLINK_HALF_CYC
) (
	// Clock and reset.
	input  wire logic clk_i,
	input  wire logic srst_i,
	// Indicator control.
	input  wire logic blink_i,
	input  wire logic steady_i,
	output logic      led_o
);
	logic [31:0] cnt_q;
	logic        ph_q;
	wire         wrap = (cnt_q == 32'(HALF_CYC - 1));

	generate
		if (HALF_CYC < 1) begin : g_bad
			$error("HALF_CYC must be at least one");
		end
	endgenerate

	// The phase toggles every half period while blinking is requested.
	always_ff @(posedge clk_i) begin
		if (srst_i || !blink_i) begin
			cnt_q <= '0;
			ph_q  <= 1'b1;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + 32'h1;
			ph_q  <= wrap ? ~ph_q : ph_q;
		end
	end

	// The indicator is a register so the pin never glitches.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			led_o <= 1'b0;
		end else begin
			led_o <= blink_i ? ph_q : steady_i;
		end
	end
endmodule

// ===== core/tfc_core.sv
// Command execution core of the cartridge tape formatter.
`timescale 1ns/1ps
module tfc_core #(
	parameter int NUM_TRACKS     = tfc_pkg::NUM_TRACKS,
	parameter int BLINK_HALF_CYC = tfc_pkg::BLINK_HALF_CYC
) (
	// Clock and reset.
	input  wire logic                 clk_i,
	input  wire logic                 srst_i,
	// Register port.
	input  wire logic [4:0]           addr_i,
	input  wire logic [15:0]          wdata_i,
	input  wire logic                 wr_i,
	input  wire logic                 rd_i,
	output logic      [15:0]          rdata_o,
	// Host data path readiness.
	input  wire logic                 host_rdy_i,
	// Transport sensors and drive.
	input  wire tfc_pkg::tfc_sense_t  sense_i,
	output tfc_pkg::tfc_drive_t       drive_o,
	output logic      [1:0]           track_o,
	output logic                      ready_led_o,
	// Maintenance test launch.
	output logic                      test_start_o,
	output logic      [7:0]           test_code_o
);
	// Execution states; the X states carry a forced track switch.
	typedef enum logic [3:0] {
		ST_IDLE, ST_WRITE, ST_XERASE, ST_XREW, ST_ERASE,
		ST_REWIND, ST_UNLOAD, ST_UREAD, ST_MAINT
	} tfc_state_t;

	// The track field is two bits, and a switch needs a track to go to.
	generate
		if (NUM_TRACKS < 2 || NUM_TRACKS > 4) begin : g_bad
			$error("NUM_TRACKS must be 2 to 4");
		end
	endgenerate

	// Status flags mirror the bits of the two status words.
	tfc_state_t          st_q, st_d;
	tfc_pkg::tfc_sense_t s, prev_q, rise;
	tfc_pkg::tfc_drive_t drv_d;
	logic [15:0] count_q, ofs_q, lp_cnt_q;
	logic [3:0]  code_q;
	logic [1:0]  track_q;
	logic offline_q, bot_q, eot_q, rew_q, wp_q, eor_q, tmo_q;
	logic te_q, fmt_q, rate_q, raw_q, past_ew_q, forced_q;

	// Asynchronous transport pins pass two flip-flops first.
	// Every sensor event is seen two cycles after its pin moves.
	tfc_sync #(
		.W ($bits(tfc_pkg::tfc_sense_t))
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    (sense_i),
		.q_o    (s)
	);

	// Edges are taken from the synchronised copy and a third register.
	// Pins must sit low through reset, or a high level reads as an edge.
	// Level uses of cart, protect and holes read the synchronised copy.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			prev_q <= '0;
		end else begin
			prev_q <= s;
		end
	end
	assign rise = s & ~prev_q;

	// Commands that run the write or erase heads obey write protect.
	function automatic logic is_wtype(input logic [3:0] c);
		is_wtype = (c == tfc_pkg::CMD_WRITE) || (c == tfc_pkg::CMD_UWR) ||
		           (c == tfc_pkg::CMD_ERASE);
	endfunction

	// Command decode uses only the second hex digit of the command word.
	// Offline refuses all but maintenance, so a dead transport can be tested.
	// Protect is tested before the track switch, so a protected cartridge is never erased.
	function automatic tfc_state_t cmd_state(input logic [3:0] c, input logic off,
	                                         input logic wp, input logic xtrk);
		logic wtype;
		wtype = is_wtype(c);
		if (off && c != tfc_pkg::CMD_MAINT)                     cmd_state = ST_IDLE;
		else if (wtype && wp)                                   cmd_state = ST_IDLE;
		else if (wtype && xtrk)                                 cmd_state = ST_XERASE;
		else if (c == tfc_pkg::CMD_WRITE || c == tfc_pkg::CMD_UWR) cmd_state = ST_WRITE;
		else if (c == tfc_pkg::CMD_ERASE)                       cmd_state = ST_ERASE;
		else if (c == tfc_pkg::CMD_REW)                         cmd_state = ST_REWIND;
		else if (c == tfc_pkg::CMD_UNLD)                        cmd_state = ST_UNLOAD;
		else if (c == tfc_pkg::CMD_URD)                         cmd_state = ST_UREAD;
		else if (c == tfc_pkg::CMD_MAINT)                       cmd_state = ST_MAINT;
		else                                                    cmd_state = ST_IDLE;
	endfunction

	// Request decode and conditions seen at command acceptance.
	// A command written while busy is dropped; the host polls busy first.
	// Past early warning short of the last track, a big record, or any erase, changes track first.
	wire [3:0] code_w  = wdata_i[tfc_pkg::CMD_LSB +: 4];
	wire       busy    = (st_q != ST_IDLE);
	wire       go      = wr_i && (addr_i == tfc_pkg::OFF_CMD) && !busy;
	wire       last    = (track_q == 2'(NUM_TRACKS - 1));
	wire       wtype_w = is_wtype(code_w);
	wire       big_rec = (count_q >= tfc_pkg::REC_LIMIT) || (code_w == tfc_pkg::CMD_ERASE);
	wire       xtrk    = past_ew_q && !last && big_rec;
	wire       go_st_n = (cmd_state(code_w, offline_q, s.wprot, xtrk) != ST_IDLE);
	wire       go_wp   = go && wtype_w && s.wprot && !offline_q;
	wire       go_x    = go && wtype_w && !s.wprot && !offline_q && xtrk;
	wire       go_rew  = go && !offline_q &&
	                     (code_w == tfc_pkg::CMD_REW || code_w == tfc_pkg::CMD_UNLD);

	// State shorthands and events during execution.
	// Each event is a one-cycle edge, so it acts at most once.
	wire wr_st   = (st_q == ST_WRITE);
	wire er_st   = (st_q == ST_ERASE);
	wire ur_st   = (st_q == ST_UREAD);
	wire unformt = (code_q == tfc_pkg::CMD_UWR);
	wire fault   = busy && (rise.pos_fault || rise.unexp_int || rise.timeout);
	wire cnt_0   = (count_q == 16'h0000);
	wire byte_go = (wr_st || ur_st) && rise.byte_req && host_rdy_i && !cnt_0;
	wire tach_go = er_st && rise.tach && !cnt_0;
	wire xrew_dn = (st_q == ST_XREW) && rise.beginning_of_tape;
	wire rew_dn  = (st_q == ST_REWIND) && rise.beginning_of_tape;
	wire unl_dn  = (st_q == ST_UNLOAD) && rise.end_of_tape;
	wire wr_eot  = wr_st && rise.end_of_tape;
	wire forced5 = wr_eot && forced_q && last;
	wire zone_ok = (track_q != 2'h0) || (lp_cnt_q == 16'h0000);

	// Next-state logic for command execution.
	// A fault in a moving state returns to idle; the flags say why.
	// Rewinds end at the start hole, unload at the end hole.
	// Maintenance waits only for the test to report done.
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (go && go_st_n) st_d = cmd_state(code_w, offline_q, s.wprot, xtrk);
			end
			ST_WRITE: begin
				if (fault || rise.end_of_tape || cnt_0) st_d = ST_IDLE;
			end
			ST_XERASE: begin
				if (fault) st_d = ST_IDLE;
				else if (rise.end_of_tape) st_d = ST_XREW;
			end
			ST_ERASE: begin
				if (fault || cnt_0) st_d = ST_IDLE;
				else if (rise.end_of_tape) st_d = last ? ST_IDLE : ST_XREW;
			end
			ST_XREW, ST_REWIND: begin
				if (fault || rise.beginning_of_tape) st_d = ST_IDLE;
			end
			ST_UNLOAD: begin
				if (fault || rise.end_of_tape) st_d = ST_IDLE;
			end
			ST_UREAD: begin
				if (fault || cnt_0 || rise.rec_end) st_d = ST_IDLE;
			end
			ST_MAINT: begin
				if (rise.test_done) st_d = ST_IDLE;
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Motor and head drive follow the state; write and erase heads only inside the recording zone.
	// On the first track the heads wait until the load point gap is run.
	// On the last track the write head drops once the end hole is seen.
	always_comb begin
		drv_d               = '0;
		drv_d.motor_fwd     = wr_st || er_st || ur_st || (st_q == ST_XERASE) ||
		                      (st_q == ST_UNLOAD);
		drv_d.motor_rev     = (st_q == ST_XREW) || (st_q == ST_REWIND);
		drv_d.write_en      = (wr_st || er_st) && zone_ok && !(last && s.end_of_tape);
		drv_d.erase_en      = (wr_st || er_st || (st_q == ST_XERASE)) && zone_ok;
		drv_d.crc_chk_en    = wr_st && !unformt;
		drv_d.preamble_only = (wr_st && unformt) || ur_st;
		drv_d.read_en       = wr_st || ur_st || er_st;
	end

	// State, captured command and drive outputs.
	// Drive lines lag the state by a cycle so they leave a flip-flop.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st_q     <= ST_IDLE;
			code_q   <= 4'h0;
			forced_q <= 1'b0;
			drive_o  <= '0;
		end else begin
			st_q     <= st_d;
			code_q   <= go ? code_w : code_q;
			forced_q <= go ? past_ew_q : forced_q;
			drive_o  <= drv_d;
		end
	end

	// Count word: host loads it while idle, the transport counts it down.
	// A host write during a command is ignored, so counts never jump.
	// An erase spends it in tach pulses, a transfer in bytes.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_q <= tfc_pkg::RESET_WORD;
			ofs_q   <= tfc_pkg::RESET_WORD;
		end else begin
			if (!busy && wr_i && addr_i == tfc_pkg::OFF_CNT) count_q <= wdata_i;
			else if (byte_go || tach_go) count_q <= count_q - 16'h1;
			if (!busy && wr_i && addr_i == tfc_pkg::OFF_OFS) ofs_q <= wdata_i;
		end
	end

	// Tape position: track, early warning passed, load point gap counter.
	// The start hole forgets early warning, as the next pass starts afresh.
	// The gap counter runs on tach pulses only while moving forward.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			track_q   <= 2'h0;
			past_ew_q <= 1'b0;
			lp_cnt_q  <= tfc_pkg::LP_GAP_PULSES;
		end else begin
			if (go_rew) track_q <= 2'h0;
			else if (xrew_dn && !last) track_q <= track_q + 2'h1;
			if (rise.beginning_of_tape || go_rew) past_ew_q <= 1'b0;
			else if (rise.ew && drv_d.motor_fwd) past_ew_q <= 1'b1;
			if (rise.lp && track_q == 2'h0) lp_cnt_q <= tfc_pkg::LP_GAP_PULSES;
			else if (rise.tach && drive_o.motor_fwd && lp_cnt_q != 16'h0000)
				lp_cnt_q <= lp_cnt_q - 16'h1;
		end
	end

	// Transport condition flags; a set wins over the clear of the same cycle.
	// Offline clears only on a new cartridge, so no unload is missed.
	// An erase meeting the end hole short of the last track switches.
	wire er_x    = er_st && rise.end_of_tape && !last;
	wire off_set = fault || (wr_eot && !forced5) || forced5 || unl_dn ||
	               (er_st && rise.end_of_tape && last);
	wire eot_set = (wr_st && cnt_0 && last && past_ew_q) ||
	               (er_st && rise.ew && last);
	wire rew_clr = xrew_dn || rew_dn || unl_dn || fault;
	wire eor_set = ur_st && rise.rec_end && !cnt_0;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			offline_q <= 1'b0;
			bot_q     <= 1'b0;
			eot_q     <= 1'b0;
			rew_q     <= 1'b0;
			wp_q      <= 1'b0;
			eor_q     <= 1'b0;
			tmo_q     <= 1'b0;
		end else begin
			offline_q <= off_set || (offline_q && !rise.cart);
			bot_q     <= rew_dn || (go ? (s.beginning_of_tape && track_q == 2'h0) : bot_q);
			eot_q     <= eot_set || (eot_q && !go);
			rew_q     <= go_x || go_rew || er_x || (rew_q && !rew_clr);
			wp_q      <= go ? s.wprot : wp_q;
			eor_q     <= eor_set || (eor_q && !go);
			tmo_q     <= (busy && rise.timeout) || (tmo_q && !go);
		end
	end

	// Error flags are cleared when a new command is accepted.
	// A set in the accept cycle wins, so refusals still report.
	wire te_set   = (go && offline_q) || go_wp || go_x || fault || wr_eot ||
	                eot_set || eor_set || (er_st && rise.end_of_tape);
	wire fmt_set  = (wr_st && rise.dropout) || (er_st && rise.amplitude);
	wire raw_set  = wr_st && ((rise.crc_fail && !unformt) || rise.dropout);
	wire rate_set = (wr_st || ur_st) && rise.byte_req && !host_rdy_i && !cnt_0;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			te_q   <= 1'b0;
			fmt_q  <= 1'b0;
			raw_q  <= 1'b0;
			rate_q <= 1'b0;
		end else begin
			te_q   <= te_set || (te_q && !go);
			fmt_q  <= fmt_set || (fmt_q && !go);
			raw_q  <= raw_set || (raw_q && !go);
			rate_q <= rate_set || (rate_q && !go);
		end
	end

	// Status words and read data selection.
	// Unused bits read as zero so the host can test whole words.
	// The command word reads back only its command digit.
	wire [15:0] tsw = {8'h00, tmo_q, busy, eor_q, wp_q, rew_q, eot_q, bot_q, offline_q};
	wire [15:0] esw = {te_q, fmt_q, 1'b0, rate_q, 3'b000, raw_q, 8'h00};
	wire [15:0] rsel = (addr_i == tfc_pkg::OFF_CMD) ? {4'h0, code_q, 8'h00} :
	                   (addr_i == tfc_pkg::OFF_CNT) ? count_q :
	                   (addr_i == tfc_pkg::OFF_OFS) ? ofs_q :
	                   (addr_i == tfc_pkg::OFF_TSW) ? tsw :
	                   (addr_i == tfc_pkg::OFF_ESW) ? esw : 16'h0000;

	// Read data stand in the cycle after the strobe only; maintenance launch pulse.
	// Read data fall back to zero, so a stale word never looks new.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o      <= 16'h0000;
			test_start_o <= 1'b0;
			test_code_o  <= 8'h00;
			track_o      <= 2'h0;
		end else begin
			rdata_o      <= rd_i ? rsel : 16'h0000;
			test_start_o <= go && code_w == tfc_pkg::CMD_MAINT;
			test_code_o  <= (go && code_w == tfc_pkg::CMD_MAINT) ? ofs_q[15:8] : test_code_o;
			track_o      <= track_q;
		end
	end

	// Ready indicator: blinks while unloading, steady with a cartridge online.
	// It goes dark once unloaded, so the cartridge may come out.
	tfc_blink #(
		.HALF_CYC (BLINK_HALF_CYC)
	) u_led (
		.clk_i    (clk_i),
		.srst_i   (srst_i),
		.blink_i  (st_q == ST_UNLOAD),
		.steady_i (s.cart && !offline_q),
		.led_o    (ready_led_o)
	);
endmodule

// ===== tb/tfc_transport_model.sv
// Transport model that answers the drive lines with tach, byte request and start hole pins.
`timescale 1ns/1ps
module tfc_transport_model (
	// Clock.
	input  wire logic                clk_i,
	// Drive from the core and events poked by the bench.
	input  wire tfc_pkg::tfc_drive_t drive_i,
	input  wire logic [15:0]         poke_i,
	output tfc_pkg::tfc_sense_t      sense_o
);
	logic [7:0] t_q   = 8'h00;
	logic       bot_q = 1'b0;

	// Motion count paces the tape; a reverse run of 64 cycles reaches the start hole.
	always_ff @(posedge clk_i) begin
		t_q <= (drive_i.motor_fwd || drive_i.motor_rev) ? t_q + 8'h01 : 8'h00;
		if (drive_i.motor_rev && t_q == 8'h3F) begin
			bot_q <= 1'b1;
		end else if (drive_i.motor_fwd) begin
			bot_q <= 1'b0;
		end
	end

	// Pins combine the bench pokes with the motion-driven pulses.
	always_comb begin
		sense_o = poke_i;
		sense_o.tach = poke_i[9] | t_q[1];
		sense_o.byte_req = poke_i[8] | (drive_i.motor_fwd & t_q[2]);
		sense_o.beginning_of_tape = poke_i[10] | bot_q;
	end
endmodule

// ===== tb/tfc_core_asserts.sv
// Assertions on the ports of the tape command core.
`timescale 1ns/1ps
module tfc_core_asserts (
	// Clock and reset.
	input wire logic                clk_i,
	input wire logic                srst_i,
	// Register port.
	input wire logic [4:0]          addr_i,
	input wire logic [15:0]         wdata_i,
	input wire logic                wr_i,
	input wire logic                rd_i,
	input wire logic [15:0]         rdata_o,
	// Drive and test launch.
	input wire tfc_pkg::tfc_drive_t drive_o,
	input wire logic                test_start_o
);
	// All checks share the core clock and its reset.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	property p_start_cause;
		test_start_o |-> ($past(wr_i, 2) && $past(wdata_i[11:8], 2) == tfc_pkg::CMD_MAINT)
			|| ($past(wr_i) && $past(wdata_i[11:8]) == tfc_pkg::CMD_MAINT);
	endproperty
	a_start_cause : assert property (p_start_cause) else $error("test launch without command");
	property p_start_pulse;
		test_start_o |=> !test_start_o;
	endproperty
	a_start_pulse : assert property (p_start_pulse) else $error("test launch too long");
	property p_uwr_nocrc;
		drive_o.preamble_only |-> !drive_o.crc_chk_en;
	endproperty
	a_uwr_nocrc : assert property (p_uwr_nocrc) else $error("crc check in raw write");
	property p_uwr_fwd;
		drive_o.preamble_only |-> drive_o.motor_fwd;
	endproperty
	a_uwr_fwd : assert property (p_uwr_fwd) else $error("raw write without motion");
	property p_heads_fwd;
		(drive_o.write_en || drive_o.erase_en) |-> drive_o.motor_fwd;
	endproperty
	a_heads_fwd : assert property (p_heads_fwd) else $error("heads on while not forward");
	property p_nop_still;
		wr_i && addr_i == tfc_pkg::OFF_CMD && wdata_i[11:9] == 3'h4 && !$past(wr_i)
			&& !drive_o.motor_fwd && !drive_o.motor_rev
			|=> (!drive_o.motor_fwd && !drive_o.motor_rev) [*3];
	endproperty
	a_nop_still : assert property (p_nop_still) else $error("status command moved tape");
	property p_esw_layout;
		rd_i && addr_i == tfc_pkg::OFF_ESW |=> (rdata_o & 16'h2EFF) == 16'h0000;
	endproperty
	a_esw_layout : assert property (p_esw_layout) else $error("error word stray bit");
	property p_tsw_layout;
		rd_i && addr_i == tfc_pkg::OFF_TSW |=> rdata_o[15:8] == 8'h00;
	endproperty
	a_tsw_layout : assert property (p_tsw_layout) else $error("status word high byte");
	property p_cmd_layout;
		rd_i && addr_i == tfc_pkg::OFF_CMD |=> rdata_o[15:12] == 4'h0 && rdata_o[7:0] == 8'h00;
	endproperty
	a_cmd_layout : assert property (p_cmd_layout) else $error("command word extra digits");

	// Main scenarios reached.
	c_maint : cover property (test_start_o);
	c_raw_write : cover property (drive_o.preamble_only);
	c_rewind : cover property (drive_o.motor_rev);
endmodule

bind tfc_core tfc_core_asserts i_chk (
	.clk_i        (clk_i),
	.srst_i       (srst_i),
	.addr_i       (addr_i),
	.wdata_i      (wdata_i),
	.wr_i         (wr_i),
	.rd_i         (rd_i),
	.rdata_o      (rdata_o),
	.drive_o      (drive_o),
	.test_start_o (test_start_o)
);

// ===== tb/tfc_core_tb.sv
// Self-checking bench for the tape command core.
`timescale 1ns/1ps
module tfc_core_tb;
	logic                clk_i      = 1'b0;
	logic                srst_i     = 1'b1;
	logic [4:0]          addr_i     = 5'h00;
	logic [15:0]         wdata_i    = 16'h0000;
	logic                wr_i       = 1'b0;
	logic                rd_i       = 1'b0;
	logic                host_rdy_i = 1'b1;
	logic [15:0]         poke       = 16'h8000;
	logic [15:0]         rdata_o;
	tfc_pkg::tfc_sense_t sense;
	tfc_pkg::tfc_drive_t drive_o;
	logic [1:0]          track_o;
	logic                ready_led_o;
	logic                test_start_o;
	logic [7:0]          test_code_o;
	logic [15:0]         v;
	logic [3:0]          nop [5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hE};
	int                  n_mismatch = 0;
	int                  samples_checked = 0;
	int                  cyc = 0;
	int                  k;

	// Core with a short blink period, and the transport on its far side.
	tfc_core #(.BLINK_HALF_CYC(4)) i_dut (
		.clk_i        (clk_i),
		.srst_i       (srst_i),
		.addr_i       (addr_i),
		.wdata_i      (wdata_i),
		.wr_i         (wr_i),
		.rd_i         (rd_i),
		.rdata_o      (rdata_o),
		.host_rdy_i   (host_rdy_i),
		.sense_i      (sense),
		.drive_o      (drive_o),
		.track_o      (track_o),
		.ready_led_o  (ready_led_o),
		.test_start_o (test_start_o),
		.test_code_o  (test_code_o)
	);
	tfc_transport_model i_tape (.clk_i(clk_i), .drive_i(drive_o), .poke_i(poke), .sense_o(sense));

	// Clock of 4 ns.
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// Hang guard.
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up;
		end
	end

	task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	// Pulses one sensor pin long enough to pass the synchroniser.
	task automatic pk(input int b);
		@(posedge clk_i);
		poke[b] <= 1'b1;
		repeat (6) @(posedge clk_i);
		poke[b] <= 1'b0;
	endtask

	// Polls the status word until the core is no longer busy.
	task automatic idle;
		k = 0;
		do begin
			rd(tfc_pkg::OFF_TSW);
			k++;
		end while (v[tfc_pkg::TS_BUSY] !== 1'b0 && k < 500);
		chk("busy", {15'h0000, v[tfc_pkg::TS_BUSY]}, 16'h0000);
	endtask

	// Takes the cartridge out and puts it back.
	task automatic reins;
		@(posedge clk_i);
		poke[15] <= 1'b0;
		repeat (6) @(posedge clk_i);
		poke[15] <= 1'b1;
		repeat (6) @(posedge clk_i);
	endtask

	// Runs an eight byte write with one disturbance and checks the error word.
	task automatic wtest(input int b, input logic [15:0] exp);
		wr(tfc_pkg::OFF_CNT, 16'h0008);
		wr(tfc_pkg::OFF_CMD, 16'h3612);
		repeat (2) @(posedge clk_i);
		#1 chk("crc check", 16'(drive_o.crc_chk_en), 16'h0001);
		if (b < 0) begin
			@(posedge clk_i);
			host_rdy_i <= 1'b0;
			repeat (20) @(posedge clk_i);
			host_rdy_i <= 1'b1;
		end else begin
			pk(b);
		end
		idle;
		rd(tfc_pkg::OFF_CNT);
		chk("count", v, 16'h0000);
		rd(tfc_pkg::OFF_ESW);
		chk("esw", v, exp);
		$display("test write %0d finished", b);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Main sequence.
	initial begin
		repeat (6) @(posedge clk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(5'h14);
		chk("unmapped", v, 16'h0000);
		foreach (nop[i]) begin
			wr(tfc_pkg::OFF_CMD, {4'hF, nop[i], 8'hA5});
			rd(tfc_pkg::OFF_TSW);
			chk("nop tsw", v, 16'h0000);
			chk("nop motion", 16'(drive_o), 16'h0000);
		end
		rd(tfc_pkg::OFF_CMD);
		chk("cmd", v, 16'h0E00);
		$display("test status finished");
		@(posedge clk_i);
		poke[14] <= 1'b1;
		repeat (4) @(posedge clk_i);
		wr(tfc_pkg::OFF_CMD, 16'h0600);
		rd(tfc_pkg::OFF_TSW);
		chk("protect tsw", v, 16'h0010);
		rd(tfc_pkg::OFF_ESW);
		chk("protect esw", v, 16'h8000);
		@(posedge clk_i);
		poke[14] <= 1'b0;
		$display("test protect finished");
		wtest(7, 16'h0100);
		wtest(6, 16'h4100);
		wtest(-1, 16'h1000);
		wr(tfc_pkg::OFF_CNT, 16'h0008);
		wr(tfc_pkg::OFF_CMD, 16'h0C00);
		repeat (2) @(posedge clk_i);
		#1 chk("raw drive", 16'({drive_o.preamble_only, drive_o.crc_chk_en}), 16'h0002);
		idle;
		wr(tfc_pkg::OFF_CNT, 16'h0100);
		wr(tfc_pkg::OFF_CMD, 16'h0D00);
		pk(5);
		idle;
		chk("eor", 16'(v[tfc_pkg::TS_EOR]), 16'h0001);
		rd(tfc_pkg::OFF_ESW);
		chk("eor esw", v, 16'h8000);
		$display("test raw finished");
		wr(tfc_pkg::OFF_OFS, 16'hA55A);
		wr(tfc_pkg::OFF_CMD, 16'h0F00);
		k = 0;
		while (test_start_o !== 1'b1 && k < 5) begin
			@(negedge clk_i);
			k++;
		end
		chk("start", 16'(test_start_o), 16'h0001);
		chk("code", 16'(test_code_o), 16'h00A5);
		pk(0);
		idle;
		$display("test maint finished");
		wr(tfc_pkg::OFF_CMD, 16'h0A00);
		rd(tfc_pkg::OFF_TSW);
		chk("rewind", 16'(v[tfc_pkg::TS_REWIND]), 16'h0001);
		idle;
		chk("rewind end", v, 16'h0002);
		chk("track", 16'(track_o), 16'h0000);
		$display("test rewind finished");
		wr(tfc_pkg::OFF_CMD, 16'h0B00);
		rd(tfc_pkg::OFF_TSW);
		chk("unload", 16'(v[tfc_pkg::TS_REWIND]), 16'h0001);
		k = 0;
		repeat (20) begin
			@(negedge clk_i);
			k += ready_led_o;
		end
		chk("blink", 16'(k > 0 && k < 20), 16'h0001);
		pk(11);
		idle;
		chk("unload end", v & 16'h0009, 16'h0001);
		repeat (4) @(negedge clk_i);
		chk("led", 16'(ready_led_o), 16'h0000);
		reins;
		$display("test unload finished");
		wr(tfc_pkg::OFF_CNT, 16'h0100);
		wr(tfc_pkg::OFF_CMD, 16'h0600);
		pk(3);
		idle;
		chk("fault", 16'(v[tfc_pkg::TS_OFFLINE]), 16'h0001);
		wr(tfc_pkg::OFF_CMD, 16'h0800);
		rd(tfc_pkg::OFF_ESW);
		chk("offline nop", v, 16'h8000);
		rd(tfc_pkg::OFF_TSW);
		chk("persist", 16'(v[tfc_pkg::TS_OFFLINE]), 16'h0001);
		reins;
		rd(tfc_pkg::OFF_TSW);
		chk("reinsert", 16'(v[tfc_pkg::TS_OFFLINE]), 16'h0000);
		$display("test fault finished");
		wr(tfc_pkg::OFF_CNT, 16'h0040);
		wr(tfc_pkg::OFF_CMD, 16'h0700);
		pk(11);
		rd(tfc_pkg::OFF_TSW);
		chk("switch rewind", 16'(v[tfc_pkg::TS_REWIND]), 16'h0001);
		idle;
		chk("next track", 16'(track_o), 16'h0001);
		wr(tfc_pkg::OFF_CMD, 16'h0700);
		repeat (2) @(posedge clk_i);
		#1 chk("erase heads", 16'({drive_o.write_en, drive_o.erase_en}), 16'h0003);
		idle;
		rd(tfc_pkg::OFF_ESW);
		chk("retry esw", v, 16'h0000);
		$display("test erase finished");
		wrap_up;
	end
endmodule
